// ---- dv/snvm_link_sva.sv ----
`timescale 1ns/1ps
module snvm_link_sva (
  // system clock and reset
  input logic clock,
  input logic rst_n,
  // link lines
  input logic cs_n,
  input logic sck,
  input logic si,
  input logic so_o,
  input logic so_oe,
  input logic hold_n,
  input logic wp_n,
  input logic so
);
  // ----------------------------------------
  // frame bookkeeping
  // ----------------------------------------
  logic [4:0] rises_r;
  logic rd_seen_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // every link line changes only just after a rise of clock, so sampling there is exact
  always_ff @(posedge clock) begin
    if (!rst_n || cs_n) begin
      rises_r <= 5'h00;
    end else if ($rose(sck)) begin
      rises_r <= rises_r + 5'h01;
    end
  end

  // a read resumed after suspend restarts mid-byte, so only the first counts
  always_ff @(posedge clock) begin
    if (!rst_n || cs_n) begin
      rd_seen_r <= 1'b0;
    end else if (so_oe) begin
      rd_seen_r <= 1'b1;
    end
  end

  sequence s_sck_fall;
    $fell(sck);
  endsequence

  sequence s_hdr_done;
    rises_r == 5'h08 || rises_r == 5'h10;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_idle_released: assert property (cs_n |-> !so_oe)
    else $error("output driven while deselected");
  a_idle_sck_low: assert property (cs_n |-> !sck)
    else $error("serial clock moves outside a frame");
  a_hold_released: assert property (!hold_n |-> !so_oe)
    else $error("output driven during suspend");
  a_so_on_fall: assert property (
    so_oe && $past(so_oe) && $changed(so_o) |-> s_sck_fall)
    else $error("output changed away from a clock fall");
  a_si_on_rise: assert property ($rose(sck) |-> $stable(si))
    else $error("input moved at a clock rise");
  a_hold_sck_low: assert property ($changed(hold_n) |-> !sck)
    else $error("suspend moved while clock high");
  a_hold_frozen: assert property (!hold_n |-> $stable(sck))
    else $error("clock moved during suspend");
  a_whole_bytes: assert property (
    $rose(cs_n) |-> rises_r == 5'h08 || rises_r == 5'h10 ||
    rises_r == 5'h18)
    else $error("frame did not end on a byte boundary");
  a_read_start: assert property (
    $rose(so_oe) && !rd_seen_r |-> s_hdr_done)
    else $error("read data began at the wrong bit");
endmodule // snvm_link_sva

// ---- dv/snvm_tb.sv ----
`timescale 1ns/1ps
module snvm_tb;
  import snvm_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock;
  logic rst_n;
  logic req;
  snvm_cmd_t cmd;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic hold_req_n;
  logic wp_req_n;
  logic busy_o;
  logic done_o;
  logic [7:0] rdata_o;
  logic wel_o;
  logic [1:0] bp_o;
  int miscompares;
  int checked;

  snvm_link_if link();

  snvm_host snvm_host_i (.clock(clock), .rst_n(rst_n), .link(link),
    .req(req), .cmd(cmd), .addr(addr), .wdata(wdata),
    .hold_req_n(hold_req_n), .wp_req_n(wp_req_n), .busy_o(busy_o),
    .done_o(done_o), .rdata_o(rdata_o));
  snvm_device snvm_device_i (.link(link), .rst_n(rst_n), .wel_o(wel_o),
    .bp_o(bp_o));
  snvm_link_sva snvm_link_sva_i (.clock(clock), .rst_n(rst_n),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so_o(link.so_o),
    .so_oe(link.so_oe), .hold_n(link.hold_n), .wp_n(link.wp_n),
    .so(link.so));

  always #50 clock = ~clock;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cycles(input int got, input int exp);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: cycles %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one command; entered and left at a falling edge, so ops run back to back
  task automatic run_op(input snvm_cmd_t c, input logic [8:0] a,
      input logic [7:0] d, input int hold_at);
    int n;
    int exp_n;
    n = 0;
    cmd = c;
    addr = a;
    wdata = d;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    while (done_o !== 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
      if (hold_at > 0 && n == hold_at) hold_req_n = 1'b0;
      if (hold_at > 0 && n == hold_at + 40) begin
        chk_byte({5'h00, busy_o, link.so_oe, link.cs_n}, 8'h04);
      end
      if (hold_at > 0 && n == hold_at + 50) hold_req_n = 1'b1;
    end
    if (n >= 1000) begin
      chk_cycles(n, 0);
      summarize();
    end
    exp_n = (c == CMD_WRITE_ENABLE_CMD || c == CMD_WRDI) ? 81 :
      (c == CMD_RDSR || c == CMD_WRSR) ? 145 : 209;
    // n starts one cycle after the request cycle
    if (hold_at == 0) chk_cycles(n + 1, exp_n);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk_byte({5'h00, wel_o, bp_o}, 8'h00);
    run_op(CMD_RDSR, 9'h000, 8'h00, 0);
    chk_byte(rdata_o, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_latch();
    run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
    run_op(CMD_RDSR, 9'h000, 8'h00, 0);
    chk_byte(rdata_o, 8'h02);
    run_op(CMD_WRITE, 9'h005, 8'h11, 0);
    run_op(CMD_RDSR, 9'h000, 8'h00, 0);
    chk_byte(rdata_o, 8'h00);
    run_op(CMD_WRITE, 9'h005, 8'h22, 0);
    run_op(CMD_READ, 9'h005, 8'h00, 0);
    chk_byte(rdata_o, 8'h11);
    run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
    run_op(CMD_WRDI, 9'h000, 8'h00, 0);
    run_op(CMD_RDSR, 9'h000, 8'h00, 0);
    chk_byte(rdata_o, 8'h00);
    $display("latch test done");
  endtask

  task automatic t_guard();
    wp_req_n = 1'b0;
    run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
    run_op(CMD_WRITE, 9'h005, 8'h33, 0);
    run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
    run_op(CMD_WRSR, 9'h000, 8'h0c, 0);
    run_op(CMD_RDSR, 9'h000, 8'h00, 0);
    chk_byte(rdata_o & 8'hfd, 8'h00);
    wp_req_n = 1'b1;
    run_op(CMD_READ, 9'h005, 8'h00, 0);
    chk_byte(rdata_o, 8'h11);
    run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
    run_op(CMD_WRSR, 9'h000, 8'hff, 0);
    run_op(CMD_RDSR, 9'h000, 8'h00, 0);
    chk_byte(rdata_o, 8'h0c);
    chk_byte({6'h00, bp_o}, 8'h03);
    $display("guard test done");
  endtask

  task automatic t_addr();
    logic [8:0] at [4] = '{9'h000, 9'h1ff, 9'h0a5, 9'h1a5};
    logic [7:0] dt [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
      run_op(CMD_WRITE, at[i], dt[i], 0);
    end
    for (int i = 0; i < 4; i++) begin
      run_op(CMD_READ, at[i], 8'h00, 0);
      chk_byte(rdata_o, dt[i]);
    end
    $display("address test done");
  endtask

  task automatic t_hold();
    run_op(CMD_WRITE_ENABLE_CMD, 9'h000, 8'h00, 0);
    run_op(CMD_WRITE, 9'h0f0, 8'h96, 60);
    run_op(CMD_READ, 9'h0f0, 8'h00, 150);
    chk_byte(rdata_o, 8'h96);
    $display("suspend test done");
  endtask

  task automatic t_retain();
    t_reset();
    run_op(CMD_READ, 9'h1a5, 8'h00, 0);
    chk_byte(rdata_o, 8'hc3);
    $display("retention test done");
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = 1'b0;
    cmd = CMD_WRITE_ENABLE_CMD;
    addr = 9'h000;
    wdata = 8'h00;
    hold_req_n = 1'b1;
    wp_req_n = 1'b1;
    miscompares = 0;
    checked = 0;
    t_reset();
    t_latch();
    t_guard();
    t_addr();
    t_hold();
    t_retain();
    summarize();
  end
endmodule // snvm_tb

// ---- verilog/snvm_device.sv ----
// Notes on behaviour
// - select high: standby, inputs ignored, output released
// - serial clock used only while selected
// - host drops select before every op-code
// - sample input on rise, change output on fall
// - static logic, clock up to 14 MHz, pausable
// - suspend low freezes clock and select
// - host moves suspend only while clock low
// - write guard low refuses all writes
// - output driven only while returning read data
// - 512 locations of 8 bits each
// - 9-bit address, top bit in op-code
// - byte committed at eighth bit, no polling
// - simple power-on reset only
// - host keeps select inactive at power-off
// - 8-bit groups, most significant bit first
// - one op-code per select period
// - writes start disabled, need write-enable latch
// - latch clears after any completed write
`timescale 1ns/1ps
module snvm_device
  import snvm_pkg::*;
(
  // link to the host
  snvm_link_if.dev link,
  // power-on reset
  input wire logic rst_n,
  // observation
  output logic wel_o,
  output logic [1:0] bp_o
);
  import snvm_pkg::*;

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] mem_r [MEM_DEPTH];
  snvm_dst_t st_r;
  snvm_dst_t st_nxt;
  logic [BIT_CNT_W-1:0] bit_r;
  logic [6:0] sh_r;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [BYTE_W-1:0] tx_r;
  logic [BYTE_W-1:0] tx_nxt;
  logic rd_on_r;
  logic rd_on_nxt;
  logic wel_r;
  logic pend_r;
  logic [1:0] bp_r;
  logic so_o_r;
  logic so_oe_r;

  // ----------------------------------------------------------------
  // qualifiers
  // ----------------------------------------------------------------
  logic act;
  logic frame_clr;
  logic byte_done;
  logic [BYTE_W-1:0] byte_in;
  logic wel_eff;
  logic wr_ok;
  logic [BYTE_W-1:0] sr_byte;
  logic is_read;
  logic is_write;
  logic mem_we;
  logic sr_we;
  logic write_enable_cmd_hit;
  logic wrdi_hit;
  logic pend_set;

  assign act = ~link.cs_n & link.hold_n;
  // a select edge during suspend is held off until suspend ends
  assign frame_clr = link.cs_n & link.hold_n;
  assign byte_in = {sh_r, link.si};
  assign byte_done = act & (bit_r == BIT_LAST);
  // a write earlier in the last frame has already spent the latch
  assign wel_eff = wel_r & ~pend_r;
  assign wr_ok = wel_eff & link.wp_n;
  assign is_read = (byte_in[7:4] == OP_MEM_HI) &
                   (byte_in[2:0] == OP_READ_LO);
  assign is_write = (byte_in[7:4] == OP_MEM_HI) &
                    (byte_in[2:0] == OP_WRITE_LO);

  always_comb begin
    sr_byte = '0;
    sr_byte[SR_WEL_BIT] = wel_eff;
    sr_byte[SR_BP0_BIT] = bp_r[0];
    sr_byte[SR_BP1_BIT] = bp_r[1];
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    rd_on_nxt = rd_on_r;
    mem_we = 1'b0;
    sr_we = 1'b0;
    write_enable_cmd_hit = 1'b0;
    wrdi_hit = 1'b0;
    pend_set = 1'b0;
    if (byte_done) begin
      unique case (st_r)
        D_OPC: begin
          st_nxt = D_SKIP;
          if (byte_in == OP_WRITE_ENABLE_CMD) begin
            write_enable_cmd_hit = 1'b1;
          end else if (byte_in == OP_WRDI) begin
            wrdi_hit = 1'b1;
          end else if (byte_in == OP_RDSR) begin
            st_nxt = D_SRRD;
            tx_nxt = sr_byte;
            rd_on_nxt = 1'b1;
          end else if (byte_in == OP_WRSR) begin
            st_nxt = D_SRWR;
          end else if (is_read) begin
            st_nxt = D_RADDR;
            addr_nxt[ADDR_W-1] = byte_in[OP_ADDR_BIT];
          end else if (is_write) begin
            st_nxt = D_WADDR;
            addr_nxt[ADDR_W-1] = byte_in[OP_ADDR_BIT];
          end
        end
        D_RADDR: begin
          st_nxt = D_RD;
          addr_nxt = {addr_r[ADDR_W-1], byte_in};
          tx_nxt = mem_r[{addr_r[ADDR_W-1], byte_in}];
          rd_on_nxt = 1'b1;
        end
        D_WADDR: begin
          st_nxt = D_WR;
          addr_nxt = {addr_r[ADDR_W-1], byte_in};
        end
        D_RD: begin
          // sequential read wraps at the top of the array
          addr_nxt = addr_r + 9'h001;
          tx_nxt = mem_r[addr_r + 9'h001];
        end
        D_WR: begin
          // a spent latch was already dropped at this frame's first
          // rise, so the raw latch lets every byte of one write through
          addr_nxt = addr_r + 9'h001;
          mem_we = wel_r & link.wp_n;
          pend_set = wel_r & link.wp_n;
        end
        D_SRRD: begin
          tx_nxt = sr_byte;
        end
        D_SRWR: begin
          st_nxt = D_SKIP;
          sr_we = wr_ok;
          pend_set = wr_ok;
        end
        D_SKIP: begin
          st_nxt = D_SKIP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // frame state, cleared whenever the select is released
  // ----------------------------------------------------------------
  always_ff @(posedge link.sck or posedge frame_clr) begin
    if (frame_clr) begin
      st_r <= D_OPC;
      bit_r <= '0;
      sh_r <= '0;
      rd_on_r <= 1'b0;
      tx_r <= '0;
    end else if (act) begin
      st_r <= st_nxt;
      bit_r <= bit_r + 3'h1;
      sh_r <= byte_in[6:0];
      rd_on_r <= rd_on_nxt;
      tx_r <= tx_nxt;
    end
  end

  // address survives select release only to be reloaded next frame
  always_ff @(posedge link.sck) begin
    if (act) begin
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // array write at bus speed
  // ----------------------------------------------------------------
  always_ff @(posedge link.sck) begin
    if (mem_we) begin
      mem_r[addr_r] <= byte_in;
    end
  end

  // ----------------------------------------------------------------
  // write-enable latch and protect bits
  // ----------------------------------------------------------------
  // the serial clock may stand still, so the power-on reset cannot
  // wait for an edge: it acts at once and loads constants only
  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      wel_r <= WEL_RESET;
      pend_r <= 1'b0;
    end else if (act) begin
      if (write_enable_cmd_hit) begin
        wel_r <= 1'b1;
      end else if (wrdi_hit) begin
        wel_r <= 1'b0;
      end else if (pend_r && st_r == D_OPC && bit_r == '0) begin
        wel_r <= 1'b0;
      end
      if (pend_set) begin
        pend_r <= 1'b1;
      end else if (st_r == D_OPC && bit_r == '0) begin
        pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      bp_r <= BP_RESET;
    end else if (sr_we) begin
      bp_r <= {byte_in[SR_BP1_BIT], byte_in[SR_BP0_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // serial output, launched on the falling edge
  // ----------------------------------------------------------------
  // suspend only masks the enable, so the pending bit is shown again
  // as soon as suspend ends and the host can still sample it
  always_ff @(negedge link.sck or posedge frame_clr) begin
    if (frame_clr) begin
      so_oe_r <= 1'b0;
      so_o_r <= 1'b0;
    end else if (act) begin
      so_oe_r <= rd_on_r;
      so_o_r <= tx_r[BIT_LAST - bit_r];
    end
  end

  assign link.so_o = so_o_r;
  assign link.so_oe = so_oe_r & link.hold_n;
  assign wel_o = wel_r;
  assign bp_o = bp_r;

endmodule // snvm_device

// ---- verilog/snvm_host.sv ----
`timescale 1ns/1ps
module snvm_host
  import snvm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to the memory
  snvm_link_if.host link,
  // command request
  input wire logic req,
  input wire snvm_pkg::snvm_cmd_t cmd,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  // pin levels
  input wire logic hold_req_n,
  input wire logic wp_req_n,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  import snvm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  snvm_hst_t st_r;
  logic [2:0] ph_r;
  logic [4:0] nbit_r;
  logic [4:0] last_r;
  logic [23:0] tx_r;
  logic [7:0] rx_r;
  logic cs_n_r;
  logic sck_r;
  logic si_r;
  logic hold_r;
  logic wp_r;
  logic busy_r;
  logic done_r;
  logic [7:0] rdata_r;
  logic so_s1;
  logic so_s2;
  logic [7:0] op;
  logic [4:0] nbits;
  logic run;
  logic hold_ok;

  // ----------------------------------------------------------------
  // frame image: op-code, low address (none for status ops), data, msb first
  // ----------------------------------------------------------------
  always_comb begin
    op = OP_WRITE_ENABLE_CMD;
    nbits = BITS_CMD;
    unique case (cmd)
      CMD_WRITE_ENABLE_CMD: begin
        op = OP_WRITE_ENABLE_CMD;
      end
      CMD_WRDI: begin
        op = OP_WRDI;
      end
      CMD_RDSR: begin
        op = OP_RDSR;
        nbits = BITS_SR;
      end
      CMD_WRSR: begin
        op = OP_WRSR;
        nbits = BITS_SR;
      end
      CMD_READ: begin
        op = {OP_MEM_HI, addr[8], OP_READ_LO};
        nbits = BITS_MEM;
      end
      CMD_WRITE: begin
        op = {OP_MEM_HI, addr[8], OP_WRITE_LO};
        nbits = BITS_MEM;
      end
      default: begin
        op = OP_WRDI;
      end
    endcase
  end

  // setup, shift and end stand still while suspend is asserted; idle still accepts a request
  assign run = hold_r;
  // suspend may move only with the clock low and not at the edge that
  // raises it; a frozen sequence must still be able to leave suspend
  assign hold_ok = ~sck_r & ~(run && st_r == H_SHIFT && ph_r == PH_RISE);

  // ----------------------------------------------------------------
  // returned bit crosses into this domain
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    so_s1 <= link.so;
    so_s2 <= so_s1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_r <= 1'b1;
      wp_r <= 1'b1;
    end else begin
      wp_r <= wp_req_n;
      if (hold_ok) begin
        hold_r <= hold_req_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= H_IDLE;
      ph_r <= '0;
      nbit_r <= '0;
      last_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      cs_n_r <= 1'b1;
      sck_r <= 1'b0;
      si_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        H_IDLE: begin
          if (req) begin
            st_r <= H_SETUP;
            busy_r <= 1'b1;
            cs_n_r <= 1'b0;
            ph_r <= '0;
            nbit_r <= '0;
            last_r <= nbits - 5'h01;
            tx_r <= {op, addr[7:0], wdata};
            if (nbits == BITS_SR) begin
              tx_r <= {op, wdata, 8'h00};
            end
          end
        end
        H_SETUP: begin
          if (run) begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == PH_LAST) begin
              st_r <= H_SHIFT;
            end
          end
        end
        H_SHIFT: begin
          if (run) begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == '0) begin
              sck_r <= 1'b0;
              si_r <= tx_r[23];
            end
            if (ph_r == PH_RISE) begin
              sck_r <= 1'b1;
              rx_r <= {rx_r[6:0], so_s2};
            end
            if (ph_r == PH_LAST) begin
              tx_r <= {tx_r[22:0], 1'b0};
              nbit_r <= nbit_r + 5'h01;
              if (nbit_r == last_r) begin
                st_r <= H_END;
              end
            end
          end
        end
        H_END: begin
          if (run) begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == '0) begin
              sck_r <= 1'b0;
            end
            if (ph_r == PH_LAST) begin
              cs_n_r <= 1'b1;
              st_r <= H_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              rdata_r <= rx_r;
            end
          end
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sck = sck_r;
  assign link.si = si_r;
  assign link.hold_n = hold_r;
  assign link.wp_n = wp_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign rdata_o = rdata_r;

endmodule // snvm_host

// ---- verilog/snvm_link_if.sv ----
`timescale 1ns/1ps
interface snvm_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  logic hold_n;
  logic wp_n;
  logic so;

  // released line reads high, as a weak pull-up would leave it
  assign so = so_oe ? so_o : 1'b1;

  modport dev (
    input cs_n,
    input sck,
    input si,
    input hold_n,
    input wp_n,
    output so_o,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    output hold_n,
    output wp_n,
    input so
  );
endinterface

// ---- verilog/snvm_pkg.sv ----
package snvm_pkg;

  // ----------------------------------------------------------------
  // array shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // op-codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [3:0] OP_MEM_HI = 4'h0;
  localparam logic [2:0] OP_READ_LO = 3'h3;
  localparam logic [2:0] OP_WRITE_LO = 3'h2;
  localparam int OP_ADDR_BIT = 3;

  // ----------------------------------------------------------------
  // status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP0_BIT = 2;
  localparam int SR_BP1_BIT = 3;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic WEL_RESET = 1'b0;

  // ----------------------------------------------------------------
  // link timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int SCK_MAX_KHZ = 14000;
  localparam int SCK_MIN_HALF_CYC =
    (CLK_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
  // three spare cycles let the returned bit cross two sync stages
  localparam int SCK_HALF_CYC = SCK_MIN_HALF_CYC + 3;
  localparam logic [2:0] PH_RISE = 3'(SCK_HALF_CYC);
  localparam logic [2:0] PH_LAST = 3'(2 * SCK_HALF_CYC - 1);
  localparam logic [4:0] BITS_CMD = 5'h08;
  localparam logic [4:0] BITS_SR = 5'h10;
  localparam logic [4:0] BITS_MEM = 5'h18;

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_WRITE_ENABLE_CMD = 3'h0,
    CMD_WRDI = 3'h1,
    CMD_RDSR = 3'h2,
    CMD_WRSR = 3'h3,
    CMD_READ = 3'h4,
    CMD_WRITE = 3'h5
  } snvm_cmd_t;

  typedef enum logic [2:0] {
    D_OPC = 3'h0,
    D_RADDR = 3'h1,
    D_WADDR = 3'h2,
    D_RD = 3'h3,
    D_WR = 3'h4,
    D_SRRD = 3'h5,
    D_SRWR = 3'h6,
    D_SKIP = 3'h7
  } snvm_dst_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_SETUP = 2'h1,
    H_SHIFT = 2'h2,
    H_END = 2'h3
  } snvm_hst_t;

endpackage
